// ===== verilog/svf_pkg.sv
// Constants for the vibration suppression filter settings block.
// Assumes all parameter settings arrive as synchronous ports on mclk_i.
// Operation
// - In automatic shaft filter mode the shaft notch frequency follows motor type and load inertia ratio.
// - Manual shaft code 00 or 01 disables the notch, 02 gives 4500 Hz, falling to 290 Hz at code 1F.
// - The torque command low-pass filter is on by default without any operator enable.
// - Automatic low-pass cut-off in rad/s is speed loop gain over one plus inertia ratio, times 10.
// - An automatic cut-off below the speed loop gain is replaced by the speed loop gain.
// - Low-pass select digit equal to 1 takes the cut-off from the manual low-pass frequency.
// - Advanced vibration suppression is enabled only for gain adjust modes 2, 3 and 4.
// - Tuning mode estimates load-side vibration frequency and handles at most two frequencies.
// - After a set number of positionings in tuning mode the tuning field turns to manual by itself.
// - Tuning digit 0 selects control 1 (2 is manual); digit 1 selects control 2 (1 tuning, 2 manual).
// - Control 1 is disabled unless both its frequencies exceed 0.9 times model loop gain over 2 pi.
// - Control 2 needs both frequencies above 5.0 plus 0.1 times model loop gain and ratio in 1.1 to 5.5.
// - A command notch change during positioning is applied about 150 ms after stop and servo-lock.
// - The command notch attenuates the chosen frequency with configured frequency and depth.
// - Command notch code 00 disables, 01 gives 2250 Hz, decreasing to 4.5 Hz at code 5F.
package svf_pkg;
    localparam int          CLK_HZ          = 40000000;
    localparam int          NOTCH_DELAY_MS  = 150;
    localparam int          NOTCH_DELAY_CYC = CLK_HZ / 1000 * NOTCH_DELAY_MS;
    localparam logic [3:0]  SEL_AUTO        = 4'h0;
    localparam logic [3:0]  SEL_MANUAL      = 4'h1;
    localparam logic [3:0]  SEL_OFF         = 4'h2;
    localparam logic [3:0]  TUNE_OFF        = 4'h0;
    localparam logic [3:0]  TUNE_RUN        = 4'h1;
    localparam logic [3:0]  TUNE_MANUAL     = 4'h2;
    localparam logic [3:0]  GAM_AUTO2       = 4'h2;
    localparam logic [3:0]  GAM_MANUAL      = 4'h3;
    localparam logic [3:0]  GAM_TWO2        = 4'h4;
    localparam int          FRAC_BITS       = 4;   // Hz values in units of 1/16 Hz
    localparam logic [15:0] CN_DIS_CODE     = 16'h0000;
    localparam logic [7:0]  CN_MAX_CODE     = 8'h5F;
    localparam logic [4:0]  SH_MAX_CODE     = 5'h1F;
    localparam logic [15:0] RST_SHAFT_HZ    = 16'h0000;
    localparam int          TUNE_POSITIONINGS = 8;
    // Shaft notch period base: frequency = 9000 / code, in Hz
    localparam logic [15:0] SH_BASE_HZ      = 16'h2328;
    // Command notch: frequency = 2250 / code divisor, truncated, in 1/16 Hz
    localparam logic [23:0] CN_BASE_Q4      = 24'h008CA0;
endpackage

// ===== verilog/svf_rom.sv
// Small registered lookup giving a per-code frequency in 1/16 Hz units.
// Assumes codes are stable for one clock before use.
`timescale 1ns/1ps
`default_nettype none
module svf_rom
    import svf_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  code_i,
    output logic      [23:0] freq_q4_o
);
    logic [23:0] divisor;

    // Divisor equals the code up to 0F; from 10 on, each row of sixteen codes
    // doubles both its starting divisor and its step, reaching 4.5 Hz at 5F
    always_comb begin
        divisor = {16'h0000, code_i};
        if (code_i >= 8'h10) begin
            divisor = {19'h00000, 1'b1, code_i[3:0]} << (code_i[7:4] - 4'h1);
        end
    end

    // Command notch frequency, base over divisor, truncated toward lower frequency
    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            if (code_i == 8'h00 || code_i > CN_MAX_CODE) begin
                freq_q4_o <= 24'h000000;
            end else begin
                freq_q4_o <= CN_BASE_Q4 / divisor;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/svf_top.sv
// Vibration suppression filter settings: shaft notch, torque low-pass,
// advanced vibration suppression enables and command notch hand-over.
// Assumes parameter inputs are synchronous to mclk_i; sample_i marks the
// control sample boundary; motor_table_hz_i is the motor-type shaft value.
`timescale 1ns/1ps
`default_nettype none
module svf_top
    import svf_pkg::*;
#(
    parameter int NOTCH_DELAY = NOTCH_DELAY_CYC
)(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        sample_i,
    input  wire logic [15:0] filter_select_param,
    input  wire logic [4:0]  shaft_notch_freq_code,
    input  wire logic [15:0] lowpass_manual_freq,
    input  wire logic [15:0] speed_loop_gain,
    input  wire logic [15:0] load_inertia_ratio,
    input  wire logic [15:0] motor_table_hz_i,
    input  wire logic [3:0]  gain_adjust_mode_param,
    input  wire logic [3:0]  function_select_four,
    input  wire logic [7:0]  vibration_tuning_mode_param,
    input  wire logic [15:0] model_loop_gain,
    input  wire logic [15:0] vsc1_vibration_freq,
    input  wire logic [15:0] vsc1_resonance_freq,
    input  wire logic [15:0] vsc2_vibration_freq,
    input  wire logic [15:0] vsc2_resonance_freq,
    input  wire logic [15:0] est_freq1_i,
    input  wire logic [15:0] est_freq2_i,
    input  wire logic        positioning_done_i,
    input  wire logic        servo_lock_i,
    input  wire logic [15:0] command_notch_param,
    output logic      [15:0] shaft_notch_hz_o,
    output logic      [15:0] lowpass_cut_o,
    output logic             lowpass_en_o,
    output logic             vsc1_en_o,
    output logic             vsc2_en_o,
    output logic      [15:0] vsc1_freq_o,
    output logic      [15:0] vsc2_freq_o,
    output logic      [7:0]  tuning_mode_o,
    output logic      [23:0] cmd_notch_q4_o,
    output logic      [3:0]  cmd_notch_depth_o,
    output logic             cmd_notch_en_o
);
    logic [3:0]  shaft_sel;
    logic [3:0]  lp_sel;
    logic [31:0] lp_auto;
    logic [15:0] lp_auto16;
    logic [15:0] shaft_next;
    logic [15:0] lp_next;
    logic        vsc_allowed;
    logic        vsc1_ok;
    logic        vsc2_ok;
    logic [31:0] lim1_x;
    logic [31:0] lim2_x10;
    logic [7:0]  tune_reg;
    logic [3:0]  pos_cnt_reg;
    logic [15:0] notch_pend_reg;
    logic [31:0] lock_cnt_reg;
    logic [15:0] notch_app_reg;
    logic [23:0] rom_q4;
    logic [7:0]  tune_seen_reg;
    logic        tune_accept;
    logic [15:0] notch_use_reg;

    assign shaft_sel = filter_select_param[3:0];
    assign lp_sel    = filter_select_param[7:4];

    // Scaled product helper
    function automatic logic [31:0] mul16(input logic [15:0] a, input logic [15:0] b);
        mul16 = a * b;
    endfunction

    // Shaft notch frequency selection
    always_comb begin
        shaft_next = RST_SHAFT_HZ;
        if (shaft_sel == SEL_AUTO) begin
            shaft_next = (load_inertia_ratio > 16'h0000) ? motor_table_hz_i - (motor_table_hz_i >> 3)
                                                          : motor_table_hz_i;
        end else if (shaft_sel == SEL_MANUAL && shaft_notch_freq_code > 5'h01) begin
            shaft_next = SH_BASE_HZ / {11'h000, shaft_notch_freq_code};
        end
    end

    // Low-pass cut-off: automatic formula with floor, or manual value
    assign lp_auto   = mul16(speed_loop_gain, 16'h000A) / ({16'h0000, load_inertia_ratio} + 32'h1);
    assign lp_auto16 = (lp_auto > 32'h0000FFFF) ? 16'hFFFF : lp_auto[15:0];
    always_comb begin
        if (lp_sel == SEL_MANUAL) begin
            lp_next = lowpass_manual_freq;
        end else if (lp_auto16 < speed_loop_gain) begin
            lp_next = speed_loop_gain;
        end else begin
            lp_next = lp_auto16;
        end
    end

    // Vibration suppression range checks, 0.9/(2pi) approx 0.1432 = 9387/65536
    assign vsc_allowed = (gain_adjust_mode_param == GAM_AUTO2) || (gain_adjust_mode_param == GAM_MANUAL)
                         || (gain_adjust_mode_param == GAM_TWO2);
    assign lim1_x   = mul16(model_loop_gain, 16'h24AB) >> 16;
    assign vsc1_ok  = ({16'h0000, vsc1_vibration_freq} > lim1_x)
                      && ({16'h0000, vsc1_resonance_freq} > lim1_x);
    assign lim2_x10 = 32'h00000032 + {16'h0000, model_loop_gain};
    assign vsc2_ok  = (vsc1_vibration_freq < vsc2_vibration_freq)
                      && (mul16(vsc2_vibration_freq, 16'h000A) > lim2_x10)
                      && (mul16(vsc2_resonance_freq, 16'h000A) > lim2_x10)
                      && (mul16(vsc2_vibration_freq, 16'h000A) > mul16(vsc1_vibration_freq, 16'h000B))
                      && (mul16(vsc2_vibration_freq, 16'h000A) < mul16(vsc1_vibration_freq, 16'h0037))
                      && function_select_four[0];

    // Coefficients update only at the sample boundary
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            shaft_notch_hz_o <= RST_SHAFT_HZ;
            lowpass_cut_o    <= 16'h0000;
            lowpass_en_o     <= 1'b1;
            vsc1_en_o        <= 1'b0;
            vsc2_en_o        <= 1'b0;
            vsc1_freq_o      <= 16'h0000;
            vsc2_freq_o      <= 16'h0000;
        end else if (ce_i && sample_i) begin
            shaft_notch_hz_o <= shaft_next;
            lowpass_cut_o    <= lp_next;
            lowpass_en_o     <= (lp_sel != SEL_OFF);
            vsc1_en_o        <= vsc_allowed && tune_reg[3:0] != TUNE_OFF && vsc1_ok;
            vsc2_en_o        <= vsc_allowed && tune_reg[7:4] != TUNE_OFF && vsc2_ok;
            vsc1_freq_o      <= (tune_reg[3:0] == TUNE_RUN) ? est_freq1_i : vsc1_vibration_freq;
            vsc2_freq_o      <= (tune_reg[7:4] == TUNE_RUN) ? est_freq2_i : vsc2_vibration_freq;
        end
    end

    // A new tuning request is taken once, while no positioning count runs;
    // comparing with the last request taken keeps the automatic switch to
    // manual from being undone by a request that has not changed
    assign tune_accept = (vibration_tuning_mode_param != tune_seen_reg) && (pos_cnt_reg == 4'h0);

    // Last tuning request taken
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tune_seen_reg <= 8'h00;
        end else if (ce_i && tune_accept) begin
            tune_seen_reg <= vibration_tuning_mode_param;
        end
    end

    // Tuning mode field, auto switch to manual after positionings
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tune_reg    <= 8'h00;
            pos_cnt_reg <= 4'h0;
        end else if (ce_i) begin
            if (tune_accept) begin
                tune_reg <= vibration_tuning_mode_param;
            end
            if (tune_reg[3:0] == TUNE_RUN || tune_reg[7:4] == TUNE_RUN) begin
                if (positioning_done_i) begin
                    if (pos_cnt_reg == 4'(TUNE_POSITIONINGS - 1)) begin
                        pos_cnt_reg <= 4'h0;
                        tune_reg    <= {(tune_reg[7:4] == TUNE_RUN) ? TUNE_MANUAL : tune_reg[7:4],
                                        (tune_reg[3:0] == TUNE_RUN) ? TUNE_MANUAL : tune_reg[3:0]};
                    end else begin
                        pos_cnt_reg <= pos_cnt_reg + 4'h1;
                    end
                end
            end else begin
                pos_cnt_reg <= 4'h0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tuning_mode_o <= 8'h00;
        end else if (ce_i) begin
            tuning_mode_o <= tune_reg;
        end
    end

    // Command notch: applied after servo-lock has held for the delay
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            notch_pend_reg <= CN_DIS_CODE;
            notch_app_reg  <= CN_DIS_CODE;
            lock_cnt_reg   <= 32'h0;
        end else if (ce_i) begin
            notch_pend_reg <= command_notch_param;
            if (!servo_lock_i) begin
                lock_cnt_reg <= 32'h0;
            end else if (lock_cnt_reg < 32'(NOTCH_DELAY)) begin
                lock_cnt_reg <= lock_cnt_reg + 32'h1;
            end else begin
                notch_app_reg <= notch_pend_reg;
            end
        end
    end

    svf_rom u_rom (
        .mclk_i    (mclk_i),
        .ce_i      (ce_i),
        .code_i    (notch_app_reg[7:0]),
        .freq_q4_o (rom_q4)
    );

    // Code copy aligned with the lookup output, so depth, enable and frequency agree
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            notch_use_reg <= CN_DIS_CODE;
        end else if (ce_i) begin
            notch_use_reg <= notch_app_reg;
        end
    end

    // Command notch outputs to the position command filter
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cmd_notch_q4_o    <= 24'h000000;
            cmd_notch_depth_o <= 4'h0;
            cmd_notch_en_o    <= 1'b0;
        end else if (ce_i && sample_i) begin
            cmd_notch_q4_o    <= rom_q4;
            cmd_notch_depth_o <= notch_use_reg[11:8];
            cmd_notch_en_o    <= (notch_use_reg[7:0] != 8'h00) && (rom_q4 != 24'h000000);
        end
    end
endmodule
`default_nettype wire

// ===== tb/svf_motor_model.sv
// Motor and load model: a move runs ten cycles, then stops and locks.
// Assumes move_i is a one-cycle request from the bench.
`timescale 1ns/1ps
`default_nettype none
module svf_motor_model (
    input  wire logic        mclk_i,
    input  wire logic        move_i,
    output logic             done_o,
    output logic             lock_o,
    output logic      [15:0] est1_o,
    output logic      [15:0] est2_o
);
    logic [3:0] run_reg = 4'h0;
    // Motion countdown
    always_ff @(posedge mclk_i) begin
        run_reg <= move_i ? 4'hA : (run_reg != 4'h0 ? run_reg - 4'h1 : 4'h0);
    end
    // Done pulse at the end of travel, lock while stopped
    assign done_o = run_reg == 4'h1;
    assign lock_o = run_reg == 4'h0;
    // Load-side vibration the estimator sees
    assign est1_o = 16'h0028;
    assign est2_o = 16'h0064;
endmodule
`default_nettype wire

// ===== tb/svf_chk_properties.sv
// Checker for the filter settings outputs.
// Bound to svf_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module svf_chk (
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire logic        ce_i,
    input wire logic        sample_i,
    input wire logic [15:0] filter_select_param,
    input wire logic [4:0]  shaft_notch_freq_code,
    input wire logic [15:0] lowpass_manual_freq,
    input wire logic [15:0] speed_loop_gain,
    input wire logic [15:0] load_inertia_ratio,
    input wire logic [3:0]  gain_adjust_mode_param,
    input wire logic [7:0]  vibration_tuning_mode_param,
    input wire logic [15:0] model_loop_gain,
    input wire logic [15:0] vsc1_vibration_freq,
    input wire logic [15:0] shaft_notch_hz_o,
    input wire logic [15:0] lowpass_cut_o,
    input wire logic        lowpass_en_o,
    input wire logic        vsc1_en_o,
    input wire logic        vsc2_en_o,
    input wire logic        cmd_notch_en_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Sample strobe and control 1 frequency floor
    wire logic        smp = ce_i && sample_i;
    wire logic [15:0] lim = 16'((32'(model_loop_gain) * 1432) / 10000);
    // Settings held for a cycle
    sequence st;
        $stable(filter_select_param) && $stable(shaft_notch_freq_code) && $stable(speed_loop_gain)
        && $stable(load_inertia_ratio) && $stable(lowpass_manual_freq) && $stable(gain_adjust_mode_param)
        && $stable(model_loop_gain) && $stable(vsc1_vibration_freq) && $stable(vibration_tuning_mode_param);
    endsequence
    rst_vals_a: assert property ($fell(sys_rst_i) |-> lowpass_en_o && shaft_notch_hz_o == 16'h0000 && !vsc1_en_o)
        else $error("reset output values wrong");
    hold_out_a: assert property (!smp |=> $stable(lowpass_cut_o) && $stable(shaft_notch_hz_o) && $stable(cmd_notch_en_o))
        else $error("output moved off a sample edge");
    lp_manual_a: assert property (st ##0 (smp && filter_select_param[7:4] == 4'h1) |=> lowpass_cut_o == $past(lowpass_manual_freq))
        else $error("manual cut-off not taken");
    lp_auto_a: assert property (st ##0 (smp && filter_select_param[7:4] == 4'h0 && load_inertia_ratio == 16'h0000)
        |=> lowpass_cut_o == ((32'($past(speed_loop_gain)) * 10 > 65535) ? 16'hFFFF
                              : 16'($past(speed_loop_gain) * 10)))
        else $error("automatic cut-off wrong");
    lp_floor_a: assert property (st ##0 (smp && filter_select_param[7:4] == 4'h0) |=> lowpass_cut_o >= $past(speed_loop_gain))
        else $error("cut-off below speed loop gain");
    shaft_man_a: assert property (st ##0 (smp && filter_select_param[3:0] == 4'h1) |=> shaft_notch_hz_o ==
        ($past(shaft_notch_freq_code) < 5'h02 ? 16'h0000 : 16'(16'h2328 / $past(shaft_notch_freq_code))))
        else $error("shaft code decode wrong");
    vsc_mode_a: assert property (st ##0 (smp && !(gain_adjust_mode_param inside {4'h2, 4'h3, 4'h4}))
        |=> !vsc1_en_o && !vsc2_en_o)
        else $error("suppression on in wrong gain mode");
    vsc1_lim_a: assert property (st ##0 (smp && vibration_tuning_mode_param[3:0] == 4'h2 && vsc1_vibration_freq <= lim)
        |=> !vsc1_en_o)
        else $error("control 1 on out of range");
    cover property (smp && filter_select_param[7:4] == 4'h1);
    cover property ($rose(vsc2_en_o));
    cover property ($rose(cmd_notch_en_o));
endmodule
bind svf_top svf_chk chk_u (.*);
`default_nettype wire

// ===== tb/testbench.sv
// Testbench for the filter settings block.
// Settings are ports; a motor model gives stop, lock and estimates.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk_i, sys_rst_i, ce_i, sample_i, move, positioning_done_i, servo_lock_i;
    logic        lowpass_en_o, vsc1_en_o, vsc2_en_o, cmd_notch_en_o;
    logic [3:0]  gain_adjust_mode_param, function_select_four, cmd_notch_depth_o;
    logic [4:0]  shaft_notch_freq_code;
    logic [7:0]  vibration_tuning_mode_param, tuning_mode_o;
    logic [15:0] filter_select_param, lowpass_manual_freq, speed_loop_gain, load_inertia_ratio, motor_table_hz_i;
    logic [15:0] model_loop_gain, vsc1_vibration_freq, vsc1_resonance_freq, vsc2_vibration_freq, vsc2_resonance_freq;
    logic [15:0] est_freq1_i, est_freq2_i, command_notch_param, shaft_notch_hz_o, lowpass_cut_o, vsc1_freq_o, vsc2_freq_o;
    logic [23:0] cmd_notch_q4_o;
    int          num_errors, compares, cyc, n;
    svf_top #(.NOTCH_DELAY(20)) dut_u (.*);
    svf_motor_model mot_u (.mclk_i(mclk_i), .move_i(move), .done_o(positioning_done_i), .lock_o(servo_lock_i),
                           .est1_o(est_freq1_i), .est2_o(est_freq2_i));
    // Clock and hang guard
    initial mclk_i = 1'b0;
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One sample boundary after the settings settle
    task automatic step();
        @(posedge mclk_i) #1 sample_i = 1'b1;
        @(posedge mclk_i) #1 sample_i = 1'b0;
        @(posedge mclk_i) #1;
    endtask
    task automatic motion();
        @(posedge mclk_i) #1 move = 1'b1;
        @(posedge mclk_i) #1 move = 1'b0;
        repeat (14) @(posedge mclk_i);
        #1;
    endtask
    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {sys_rst_i, ce_i, sample_i, move} = 4'hC;
        {filter_select_param, lowpass_manual_freq, speed_loop_gain, load_inertia_ratio, motor_table_hz_i} = '0;
        {model_loop_gain, vsc1_vibration_freq, vsc1_resonance_freq, vsc2_vibration_freq, vsc2_resonance_freq} = '0;
        {gain_adjust_mode_param, function_select_four, shaft_notch_freq_code, vibration_tuning_mode_param} = '0;
        command_notch_param = 16'h0000;
        repeat (4) @(posedge mclk_i);
        #1 sys_rst_i = 1'b0;
        @(posedge mclk_i) #1;
        chk("lp_en", lowpass_en_o, 24'h1);
        speed_loop_gain = 16'h0064;
        step();
        chk("lp_auto", lowpass_cut_o, 24'h0003E8);
        load_inertia_ratio = 16'h0013;
        step();
        chk("lp_floor", lowpass_cut_o, 24'h000064);
        {filter_select_param, lowpass_manual_freq} = {16'h0011, 16'h0BB8};
        for (n = 0; n < 3; n++) begin
            shaft_notch_freq_code = n == 0 ? 5'h01 : (n == 1 ? 5'h02 : 5'h1F);
            step();
            chk("shaft_man", shaft_notch_hz_o, n == 0 ? 24'h0 : (n == 1 ? 24'h001194 : 24'h000122));
        end
        chk("lp_man", lowpass_cut_o, 24'h000BB8);
        {filter_select_param, load_inertia_ratio, motor_table_hz_i} = {16'h0010, 16'h0000, 16'h0320};
        step();
        chk("shaft_auto", shaft_notch_hz_o, 24'h000320);
        {filter_select_param, load_inertia_ratio} = {16'h0020, 16'h0001};
        step();
        chk("shaft_load", shaft_notch_hz_o, 24'h0002BC);
        chk("lp_off", lowpass_en_o, 24'h0);
        {ce_i, filter_select_param} = {1'b0, 16'h0000};
        step();
        chk("ce_hold", lowpass_en_o, 24'h0);
        ce_i = 1'b1;
        // Both suppression controls in manual over gain modes 1 to 5
        {model_loop_gain, vsc1_vibration_freq, vsc1_resonance_freq} = {16'h0064, 16'h0032, 16'h0032};
        {vsc2_vibration_freq, vsc2_resonance_freq, function_select_four} = {16'h0064, 16'h0064, 4'h1};
        vibration_tuning_mode_param = 8'h22;
        for (n = 1; n < 6; n++) begin
            gain_adjust_mode_param = 4'(n);
            step();
            chk("vsc1_en", vsc1_en_o, n inside {2, 3, 4});
            chk("vsc2_en", vsc2_en_o, n inside {2, 3, 4});
        end
        {gain_adjust_mode_param, vsc2_vibration_freq} = {4'h3, 16'h012C};
        step();
        chk("vsc2_ratio", vsc2_en_o, 24'h0);
        chk("vsc1_ok", vsc1_en_o, 24'h1);
        chk("vsc2_man", vsc2_freq_o, 24'h00012C);
        vsc1_vibration_freq = 16'h000A;
        step();
        chk("vsc1_low", vsc1_en_o, 24'h0);
        {vsc1_vibration_freq, vibration_tuning_mode_param} = {16'h0032, 8'h11};
        step();
        chk("vsc1_est", vsc1_freq_o, 24'h000028);
        chk("vsc2_est", vsc2_freq_o, 24'h000064);
        repeat (8) motion();
        step();
        chk("tune_done", tuning_mode_o, 24'h000022);
        // Notch change while moving waits for lock plus the delay
        @(posedge mclk_i) #1 move = 1'b1;
        command_notch_param = 16'h0301;
        @(posedge mclk_i) #1 move = 1'b0;
        for (n = 0; n < 20 && cmd_notch_en_o !== 1'b1; n++) step();
        chk("cn_late", (n > 5) && (n < 20), 24'h1);
        chk("cn_freq", cmd_notch_q4_o, 24'h008CA0);
        chk("cn_depth", cmd_notch_depth_o, 24'h3);
        command_notch_param = 16'h005F;
        repeat (12) step();
        chk("cn_low", cmd_notch_q4_o, 24'h000048);
        chk("cn_low_en", cmd_notch_en_o, 24'h1);
        command_notch_param = 16'h0000;
        repeat (12) step();
        chk("cn_off", cmd_notch_en_o, 24'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
